/* sctl_pkg.sv */
// Register map, field layout, reset values and state record of the bank
package sctl_pkg;

   localparam int ADDR_W = 20;
   localparam int IDX_W  = 18;

   // Register indices; the byte address is four times the index
   localparam logic [17:0] IDX_GCTL_A   = 18'h30005;
   localparam logic [17:0] IDX_TSEL_A   = 18'h30006;
   localparam logic [17:0] IDX_TXPD_A   = 18'h30007;
   localparam logic [17:0] IDX_ISTAT    = 18'h30010;
   localparam logic [17:0] IDX_IMASK    = 18'h30011;
   localparam logic [17:0] IDX_RXCFG_AC = 18'h30023;
   localparam logic [17:0] IDX_CFG_AC   = 18'h30024;
   localparam logic [17:0] IDX_RXCFG_AD = 18'h30033;
   localparam logic [17:0] IDX_CFG_AD   = 18'h30034;
   localparam logic [17:0] IDX_GCTL_B   = 18'h30105;
   localparam logic [17:0] IDX_TSEL_B   = 18'h30106;
   localparam logic [17:0] IDX_TXPD_B   = 18'h30107;
   localparam logic [17:0] IDX_RXCFG_BC = 18'h30123;
   localparam logic [17:0] IDX_CFG_BC   = 18'h30124;
   localparam logic [17:0] IDX_RXCFG_BD = 18'h30133;
   localparam logic [17:0] IDX_CFG_BD   = 18'h30134;

   // Field positions
   localparam int BIT_MASK    = 1;
   localparam int BIT_SWRST   = 2;
   localparam int BIT_TXPD    = 3;
   localparam int BIT_RXPD    = 4;
   localparam int BIT_G_RSVD1 = 5;
   localparam int BIT_TEST    = 7;
   localparam int BIT_RX_PD   = 1;
   localparam int BIT_RX_RSVD = 2;
   localparam int BIT_PD_C    = 0;
   localparam int BIT_PD_D    = 1;
   localparam int TSEL_W      = 5;

   // Reset values
   localparam logic       RST_CHAN_MASK = 1'b1;
   localparam logic       RST_BLK_MASK  = 1'b1;
   localparam logic       RST_SOFT      = 1'b0;
   localparam logic       RST_TEST      = 1'b0;
   localparam logic       RST_PD        = 1'b0;
   localparam logic       RST_CHAN_HOLD = 1'b1;
   localparam logic       RSVD_ONE      = 1'b1;
   localparam logic [4:0] RST_TSEL      = 5'h00;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [3:0] {
      SEL_NONE  = 4'h0,
      SEL_GCTL  = 4'h1,
      SEL_TSEL  = 4'h2,
      SEL_TXPD  = 4'h3,
      SEL_CFG   = 4'h4,
      SEL_RXCFG = 4'h5,
      SEL_ISTAT = 4'h6,
      SEL_IMASK = 4'h7
   } reg_sel_type;

   typedef struct packed {
      reg_sel_type sel;
      logic [1:0]  unit;
   } decode_type;

   typedef struct packed {
      logic [3:0]      chan_mask;
      logic [3:0]      chan_swrst;
      logic [3:0]      chan_test;
      logic [3:0]      chan_txpd;
      logic [3:0]      chan_rxpd;
      logic [1:0]      blk_mask;
      logic [1:0]      blk_swrst;
      logic [1:0]      blk_txpd;
      logic [1:0]      blk_rxpd;
      logic [1:0]      blk_test;
      logic [1:0][4:0] tsel;
      logic [7:0]      irq_stat;
      logic [7:0]      irq_mask;
      logic            aw_have;
      logic            w_have;
      logic [17:0]     waddr;
      logic [7:0]      wdata;
      logic            wstrb0;
      logic            awready;
      logic            wready;
      logic            bvalid;
      logic [1:0]      bresp;
      logic            arready;
      logic            rvalid;
      logic [7:0]      rdata;
      logic [1:0]      rresp;
      logic [3:0]      chan_reset;
      logic [3:0]      test_mode;
      logic [3:0]      tx_pd;
      logic [3:0]      rx_pd;
      logic [1:0][4:0] tsel_out;
      logic            irq;
   } state_type;

   localparam state_type STATE_RST = '{
      chan_mask:  {4{RST_CHAN_MASK}},
      chan_swrst: {4{RST_SOFT}},
      chan_test:  {4{RST_TEST}},
      chan_txpd:  {4{RST_PD}},
      chan_rxpd:  {4{RST_PD}},
      blk_mask:   {2{RST_BLK_MASK}},
      blk_swrst:  {2{RST_SOFT}},
      blk_txpd:   {2{RST_PD}},
      blk_rxpd:   {2{RST_PD}},
      blk_test:   {2{RST_TEST}},
      tsel:       {2{RST_TSEL}},
      chan_reset: {4{RST_CHAN_HOLD}},
      tsel_out:   {2{RST_TSEL}},
      default:    '0};

endpackage : sctl_pkg

/* serdes_channel_global_ctrl.sv */
// Channel and block control registers of a two-block transceiver, AXI4-Lite
`timescale 1ns/10ps

module serdes_channel_global_ctrl (
   input  logic                                clk_in,
   input  logic                                reset_in,
   input  logic [sctl_pkg::ADDR_W-1:0]         awaddr_in,
   input  logic                                awvalid_in,
   output logic                                awready_out,
   input  logic [31:0]                         wdata_in,
   input  logic [3:0]                          wstrb_in,
   input  logic                                wvalid_in,
   output logic                                wready_out,
   output logic [1:0]                          bresp_out,
   output logic                                bvalid_out,
   input  logic                                bready_in,
   input  logic [sctl_pkg::ADDR_W-1:0]         araddr_in,
   input  logic                                arvalid_in,
   output logic                                arready_out,
   output logic [31:0]                         rdata_out,
   output logic [1:0]                          rresp_out,
   output logic                                rvalid_out,
   input  logic                                rready_in,
   input  logic [3:0]                          chan_tx_alarm_in,
   input  logic [3:0]                          chan_rx_alarm_in,
   output logic [3:0]                          chan_reset_out,
   output logic [3:0]                          chan_test_mode_out,
   output logic [3:0]                          chan_tx_power_down_out,
   output logic [3:0]                          chan_rx_power_down_out,
   output logic [1:0][sctl_pkg::TSEL_W-1:0]    block_test_select_out,
   output logic                                irq_out
);

   ////////////////////////////////////////////////////////////////////////
   // Address decode, shared by the write and read paths

   function automatic sctl_pkg::decode_type decode(
      input logic [sctl_pkg::IDX_W-1:0] idx);
      decode = '{sel: sctl_pkg::SEL_NONE, unit: 2'h0};
      case (idx)
         sctl_pkg::IDX_GCTL_A:   decode = '{sctl_pkg::SEL_GCTL, 2'h0};
         sctl_pkg::IDX_GCTL_B:   decode = '{sctl_pkg::SEL_GCTL, 2'h1};
         sctl_pkg::IDX_TSEL_A:   decode = '{sctl_pkg::SEL_TSEL, 2'h0};
         sctl_pkg::IDX_TSEL_B:   decode = '{sctl_pkg::SEL_TSEL, 2'h1};
         sctl_pkg::IDX_TXPD_A:   decode = '{sctl_pkg::SEL_TXPD, 2'h0};
         sctl_pkg::IDX_TXPD_B:   decode = '{sctl_pkg::SEL_TXPD, 2'h1};
         sctl_pkg::IDX_CFG_AC:   decode = '{sctl_pkg::SEL_CFG, 2'h0};
         sctl_pkg::IDX_CFG_AD:   decode = '{sctl_pkg::SEL_CFG, 2'h1};
         sctl_pkg::IDX_CFG_BC:   decode = '{sctl_pkg::SEL_CFG, 2'h2};
         sctl_pkg::IDX_CFG_BD:   decode = '{sctl_pkg::SEL_CFG, 2'h3};
         sctl_pkg::IDX_RXCFG_AC: decode = '{sctl_pkg::SEL_RXCFG, 2'h0};
         sctl_pkg::IDX_RXCFG_AD: decode = '{sctl_pkg::SEL_RXCFG, 2'h1};
         sctl_pkg::IDX_RXCFG_BC: decode = '{sctl_pkg::SEL_RXCFG, 2'h2};
         sctl_pkg::IDX_RXCFG_BD: decode = '{sctl_pkg::SEL_RXCFG, 2'h3};
         sctl_pkg::IDX_ISTAT:    decode = '{sctl_pkg::SEL_ISTAT, 2'h0};
         sctl_pkg::IDX_IMASK:    decode = '{sctl_pkg::SEL_IMASK, 2'h0};
         default:                decode = '{sctl_pkg::SEL_NONE, 2'h0};
      endcase
   endfunction : decode

   function automatic logic [7:0] read_reg(input sctl_pkg::decode_type d,
                                           input sctl_pkg::state_type st);
      logic       b;
      logic [7:0] r;
      b = d.unit[0];
      r = 8'h00;
      // Reserved bit 0 and unused bits are never stored; they read as 0, except the reserved-one bits, which read as 1
      case (d.sel)
         sctl_pkg::SEL_GCTL: begin
            r[sctl_pkg::BIT_MASK]    = st.blk_mask[b];
            r[sctl_pkg::BIT_SWRST]   = st.blk_swrst[b];
            r[sctl_pkg::BIT_TXPD]    = st.blk_txpd[b];
            r[sctl_pkg::BIT_RXPD]    = st.blk_rxpd[b];
            r[sctl_pkg::BIT_G_RSVD1] = sctl_pkg::RSVD_ONE;
            r[sctl_pkg::BIT_TEST]    = st.blk_test[b];
         end
         sctl_pkg::SEL_TSEL: begin
            r[sctl_pkg::TSEL_W-1:0] = st.tsel[b];
         end
         sctl_pkg::SEL_TXPD: begin
            r[sctl_pkg::BIT_PD_C] = st.chan_txpd[{b, 1'b0}];
            r[sctl_pkg::BIT_PD_D] = st.chan_txpd[{b, 1'b1}];
         end
         sctl_pkg::SEL_CFG: begin
            r[sctl_pkg::BIT_MASK]  = st.chan_mask[d.unit];
            r[sctl_pkg::BIT_SWRST] = st.chan_swrst[d.unit];
            r[sctl_pkg::BIT_TEST]  = st.chan_test[d.unit];
         end
         sctl_pkg::SEL_RXCFG: begin
            r[sctl_pkg::BIT_RX_PD]   = st.chan_rxpd[d.unit];
            r[sctl_pkg::BIT_RX_RSVD] = sctl_pkg::RSVD_ONE;
         end
         sctl_pkg::SEL_ISTAT: r = st.irq_stat;
         sctl_pkg::SEL_IMASK: r = st.irq_mask;
         default:             r = 8'h00;
      endcase
      return r;
   endfunction : read_reg

   ////////////////////////////////////////////////////////////////////////
   // State

   sctl_pkg::state_type   s_r;
   sctl_pkg::state_type   s_nxt;
   sctl_pkg::decode_type  wr_dec;
   sctl_pkg::decode_type  rd_dec;
   logic                  wr_commit;
   logic [7:0]            stat_clr;
   logic [3:0]            hold_w;
   logic [3:0]            test_w;
   logic [3:0]            txpd_w;
   logic [3:0]            rxpd_w;
   logic [3:0]            open_w;

   ////////////////////////////////////////////////////////////////////////
   // Per-channel effect of channel and block bits

   for (genvar c = 0; c < 4; c++) begin : g_chan
      // Block bits win: any block bit forces the channel whatever its own
      assign hold_w[c] = s_r.blk_swrst[c>>1] | s_r.chan_swrst[c];
      assign test_w[c] = s_r.blk_test[c>>1] | s_r.chan_test[c];
      assign txpd_w[c] = s_r.blk_txpd[c>>1] | s_r.chan_txpd[c];
      assign rxpd_w[c] = s_r.blk_rxpd[c>>1] | s_r.chan_rxpd[c];
      assign open_w[c] = ~(s_r.blk_mask[c>>1] | s_r.chan_mask[c]);
   end : g_chan

   ////////////////////////////////////////////////////////////////////////
   // Next state

   always_comb begin
      s_nxt     = s_r;
      wr_dec    = decode(s_r.waddr);
      rd_dec    = decode(araddr_in[sctl_pkg::ADDR_W-1:2]);
      wr_commit = s_r.aw_have && s_r.w_have && !s_r.bvalid;
      stat_clr  = 8'h00;

      if (awvalid_in && s_r.awready) begin
         s_nxt.aw_have = 1'b1;
         s_nxt.waddr   = awaddr_in[sctl_pkg::ADDR_W-1:2];
      end
      if (wvalid_in && s_r.wready) begin
         s_nxt.w_have = 1'b1;
         s_nxt.wdata  = wdata_in[7:0];
         s_nxt.wstrb0 = wstrb_in[0];
      end

      if (wr_commit) begin
         s_nxt.aw_have = 1'b0;
         s_nxt.w_have  = 1'b0;
         s_nxt.bvalid  = 1'b1;
         s_nxt.bresp   = (wr_dec.sel == sctl_pkg::SEL_NONE) ?
                         sctl_pkg::RESP_SLVERR : sctl_pkg::RESP_OKAY;
         // Only lane 0 holds register bits; other lanes are ignored
         if (s_r.wstrb0) begin
            case (wr_dec.sel)
               sctl_pkg::SEL_GCTL: begin
                  s_nxt.blk_mask[wr_dec.unit[0]] =
                     s_r.wdata[sctl_pkg::BIT_MASK];
                  s_nxt.blk_swrst[wr_dec.unit[0]] =
                     s_r.wdata[sctl_pkg::BIT_SWRST];
                  s_nxt.blk_txpd[wr_dec.unit[0]] =
                     s_r.wdata[sctl_pkg::BIT_TXPD];
                  s_nxt.blk_rxpd[wr_dec.unit[0]] =
                     s_r.wdata[sctl_pkg::BIT_RXPD];
                  s_nxt.blk_test[wr_dec.unit[0]] =
                     s_r.wdata[sctl_pkg::BIT_TEST];
               end
               sctl_pkg::SEL_TSEL: begin
                  s_nxt.tsel[wr_dec.unit[0]] =
                     s_r.wdata[sctl_pkg::TSEL_W-1:0];
               end
               sctl_pkg::SEL_TXPD: begin
                  s_nxt.chan_txpd[{wr_dec.unit[0], 1'b0}] =
                     s_r.wdata[sctl_pkg::BIT_PD_C];
                  s_nxt.chan_txpd[{wr_dec.unit[0], 1'b1}] =
                     s_r.wdata[sctl_pkg::BIT_PD_D];
               end
               sctl_pkg::SEL_CFG: begin
                  s_nxt.chan_mask[wr_dec.unit] =
                     s_r.wdata[sctl_pkg::BIT_MASK];
                  // Not self-clearing: only a later write or reset_in drops it
                  s_nxt.chan_swrst[wr_dec.unit] =
                     s_r.wdata[sctl_pkg::BIT_SWRST];
                  s_nxt.chan_test[wr_dec.unit] =
                     s_r.wdata[sctl_pkg::BIT_TEST];
               end
               sctl_pkg::SEL_RXCFG: begin
                  s_nxt.chan_rxpd[wr_dec.unit] =
                     s_r.wdata[sctl_pkg::BIT_RX_PD];
               end
               sctl_pkg::SEL_ISTAT: stat_clr = s_r.wdata;
               sctl_pkg::SEL_IMASK: s_nxt.irq_mask = s_r.wdata;
               default: ;
            endcase
         end
      end
      if (s_r.bvalid && bready_in) begin
         s_nxt.bvalid = 1'b0;
      end
      s_nxt.awready = !s_nxt.aw_have && !s_nxt.bvalid;
      s_nxt.wready  = !s_nxt.w_have && !s_nxt.bvalid;

      if (arvalid_in && s_r.arready) begin
         s_nxt.rvalid = 1'b1;
         s_nxt.rdata  = read_reg(rd_dec, s_r);
         s_nxt.rresp  = (rd_dec.sel == sctl_pkg::SEL_NONE) ?
                        sctl_pkg::RESP_SLVERR : sctl_pkg::RESP_OKAY;
      end
      if (s_r.rvalid && rready_in) begin
         s_nxt.rvalid = 1'b0;
      end
      s_nxt.arready = !s_nxt.rvalid;

      // Set wins over a clear in the same cycle so no alarm is lost
      s_nxt.irq_stat = (s_r.irq_stat & ~stat_clr) |
                       {chan_rx_alarm_in, chan_tx_alarm_in};
      // Channel and block mask gate both alarm kinds before the fine mask
      s_nxt.irq = |(s_r.irq_stat & ~s_r.irq_mask &
                    {open_w, open_w});

      // Hardware reset reaches the channel through the reset state
      s_nxt.chan_reset = hold_w;
      s_nxt.test_mode  = test_w;
      s_nxt.tx_pd      = txpd_w;
      s_nxt.rx_pd      = rxpd_w;
      s_nxt.tsel_out   = s_r.tsel;
   end

   // Soft resets never touch this register: only reset_in clears it
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         s_r <= sctl_pkg::STATE_RST;
      end else begin
         s_r <= s_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Outputs

   assign awready_out            = s_r.awready;
   assign wready_out             = s_r.wready;
   assign bvalid_out             = s_r.bvalid;
   assign bresp_out              = s_r.bresp;
   assign arready_out            = s_r.arready;
   assign rvalid_out             = s_r.rvalid;
   assign rdata_out              = {24'h000000, s_r.rdata};
   assign rresp_out              = s_r.rresp;
   assign chan_reset_out         = s_r.chan_reset;
   assign chan_test_mode_out     = s_r.test_mode;
   assign chan_tx_power_down_out = s_r.tx_pd;
   assign chan_rx_power_down_out = s_r.rx_pd;
   assign block_test_select_out  = s_r.tsel_out;
   assign irq_out                = s_r.irq;

   ////////////////////////////////////////////////////////////////////////
   // Checks

   default clocking cb @(posedge clk_in); endclocking
   default disable iff (reset_in);

   sequence soft_held_s;
      s_r.chan_swrst[0] && !wr_commit;
   endsequence

   sequence blk_reset_s;
      s_r.blk_swrst[0] ##1 s_r.blk_swrst[0];
   endsequence

   mask_reset_val_a:
      assert property ($fell(reset_in) |->
                       s_r.chan_mask == 4'hF && s_r.blk_mask == 2'h3)
      else $error("masks not set after reset");

   chan_mask_gate_a:
      assert property ((s_r.chan_mask == 4'hF && s_r.irq_mask == 8'h00)
                       |=> !irq_out)
      else $error("channel mask did not override alarm mask");

   soft_reset_hold_a:
      assert property (soft_held_s |=> s_r.chan_swrst[0] ##0
                       chan_reset_out[0])
      else $error("channel soft reset cleared itself");

   chan_test_mode_a:
      assert property ((!s_r.blk_test[1] && s_r.chan_test[2]) |=>
                       chan_test_mode_out[2])
      else $error("channel test enable ignored");

   blk_test_force_a:
      assert property (s_r.blk_test[0] |=> chan_test_mode_out[1:0] == 2'h3)
      else $error("block test enable did not force both channels");

   blk_mask_gate_a:
      assert property ((&s_r.blk_mask && s_r.chan_mask == 4'h0) |=>
                       !irq_out)
      else $error("block mask did not override channel masks");

   blk_reset_both_a:
      assert property (blk_reset_s |-> chan_reset_out[1:0] == 2'h3)
      else $error("block soft reset did not hold both channels");

   blk_tx_pd_a:
      assert property (s_r.blk_txpd[1] |=> chan_tx_power_down_out[3:2] == 2'h3)
      else $error("block transmit power-down not applied");

   blk_rx_pd_a:
      assert property (s_r.blk_rxpd[0] |=> chan_rx_power_down_out[1:0] == 2'h3)
      else $error("block receive power-down not applied");

   test_select_out_a:
      assert property ($changed(s_r.tsel) |=>
                       block_test_select_out == $past(s_r.tsel))
      else $error("test select not driven out");

   ////////////////////////////////////////////////////////////////////////
   // Reset values, per-channel paths and the clear side of the test and receive power-down overrides

   sequence reset_done_s;
      $fell(reset_in);
   endsequence

   soft_reset_val_a:
      assert property (reset_done_s |-> s_r.chan_swrst == 4'h0 &&
                       s_r.blk_swrst == 2'h0 && chan_reset_out == 4'hF)
      else $error("soft reset bits not clear after reset");

   test_reset_val_a:
      assert property (reset_done_s |-> chan_test_mode_out == 4'h0 &&
                       s_r.chan_test == 4'h0 && s_r.blk_test == 2'h0)
      else $error("test enables not clear after reset");

   blk_reset_keep_a:
      assert property ((s_r.blk_swrst[1] && !wr_commit) |=>
                       s_r.blk_swrst[1])
      else $error("block soft reset cleared itself");

   chan_reset_or_a:
      assert property ((s_r.blk_swrst[1] || s_r.chan_swrst[2]) |=>
                       chan_reset_out[2])
      else $error("channel reset is not the OR of its sources");

   blk_mask_irq_a:
      assert property (s_r.blk_mask == 2'h3 |=> !irq_out)
      else $error("block masks did not block the interrupt");

   alarm_sticky_a:
      assert property (chan_tx_alarm_in[0] |=> s_r.irq_stat[0])
      else $error("alarm did not set its status bit");

   chan_test_off_a:
      assert property ((!s_r.blk_test[0] && !s_r.chan_test[0]) |=>
                       !chan_test_mode_out[0])
      else $error("channel left in test mode");

   chan_tx_pd_a:
      assert property (s_r.chan_txpd[0] |=> chan_tx_power_down_out[0])
      else $error("channel transmit power-down not applied");

   chan_rx_pd_a:
      assert property (s_r.chan_rxpd[3] |=> chan_rx_power_down_out[3])
      else $error("channel receive power-down not applied");

   rx_pd_off_a:
      assert property ((!s_r.blk_rxpd[1] && !s_r.chan_rxpd[2]) |=>
                       !chan_rx_power_down_out[2])
      else $error("receiver powered down with no bit set");

endmodule : serdes_channel_global_ctrl

/* serdes_channel_global_ctrl_test.sv */
// Self-checking bench for the transceiver channel and block control bank
`timescale 1ns/10ps
module serdes_channel_global_ctrl_test;
   logic            clk_in      = 1'h0;
   logic            reset_in    = 1'h1;
   logic [19:0]     awaddr_in   = 20'h0;
   logic [19:0]     araddr_in   = 20'h0;
   logic            awvalid_in  = 1'h0;
   logic            wvalid_in   = 1'h0;
   logic            bready_in   = 1'h0;
   logic            arvalid_in  = 1'h0;
   logic            rready_in   = 1'h0;
   logic [31:0]     wdata_in    = 32'h0;
   logic [3:0]      wstrb_in    = 4'h0;
   logic [7:0]      alarm       = 8'h0;
   logic [31:0]     rdata_out;
   logic            awready_out, wready_out, bvalid_out, arready_out;
   logic            rvalid_out, irq_out;
   logic [1:0]      bresp_out, rresp_out;
   logic [3:0]      rst_o, test_o, txpd_o, rxpd_o;
   logic [1:0][4:0] tsel_o;
   int              miscompares = 0;
   int              check_count = 0;
   int              seed        = 59;
   int              m [16];
   // Table order: global A/B, select A/B, tx pd A/B, cfg x4, rx cfg x4,
   // alarm status, alarm mask
   logic [17:0] tbl [16] = '{sctl_pkg::IDX_GCTL_A, sctl_pkg::IDX_GCTL_B,
      sctl_pkg::IDX_TSEL_A, sctl_pkg::IDX_TSEL_B, sctl_pkg::IDX_TXPD_A,
      sctl_pkg::IDX_TXPD_B, sctl_pkg::IDX_CFG_AC, sctl_pkg::IDX_CFG_AD,
      sctl_pkg::IDX_CFG_BC, sctl_pkg::IDX_CFG_BD, sctl_pkg::IDX_RXCFG_AC,
      sctl_pkg::IDX_RXCFG_AD, sctl_pkg::IDX_RXCFG_BC,
      sctl_pkg::IDX_RXCFG_BD, sctl_pkg::IDX_ISTAT, sctl_pkg::IDX_IMASK};
   int wm [16] = '{8'h9E, 8'h9E, 8'h1F, 8'h1F, 8'h03, 8'h03, 8'h86, 8'h86,
      8'h86, 8'h86, 8'h02, 8'h02, 8'h02, 8'h02, 8'h00, 8'hFF};
   int on [16] = '{8'h20, 8'h20, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
      8'h00, 8'h00, 8'h04, 8'h04, 8'h04, 8'h04, 8'h00, 8'h00};
   int rv [16] = '{8'h22, 8'h22, 8'h00, 8'h00, 8'h00, 8'h00, 8'h02, 8'h02,
      8'h02, 8'h02, 8'h04, 8'h04, 8'h04, 8'h04, 8'h00, 8'h00};

   serdes_channel_global_ctrl dut_u (.clk_in(clk_in), .reset_in(reset_in),
      .awaddr_in(awaddr_in), .awvalid_in(awvalid_in),
      .awready_out(awready_out), .wdata_in(wdata_in), .wstrb_in(wstrb_in),
      .wvalid_in(wvalid_in), .wready_out(wready_out), .bresp_out(bresp_out),
      .bvalid_out(bvalid_out), .bready_in(bready_in), .araddr_in(araddr_in),
      .arvalid_in(arvalid_in), .arready_out(arready_out),
      .rdata_out(rdata_out), .rresp_out(rresp_out), .rvalid_out(rvalid_out),
      .rready_in(rready_in), .chan_tx_alarm_in(alarm[3:0]),
      .chan_rx_alarm_in(alarm[7:4]), .chan_reset_out(rst_o),
      .chan_test_mode_out(test_o), .chan_tx_power_down_out(txpd_o),
      .chan_rx_power_down_out(rxpd_o), .block_test_select_out(tsel_o),
      .irq_out(irq_out));

   always #50 clk_in = ~clk_in;

   ////////////////////////////////////////////////////////////////////////
   task automatic cmp(input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         miscompares++;
         $display("[ERR] %0t exp %h got %h", $time, exp, got);
      end
   endtask : cmp

   function automatic int find(input logic [17:0] x);
      for (int k = 0; k < 16; k++)
         if (tbl[k] == x) return k;
      return -1;
   endfunction : find

   // Expected control outputs, worked from the model registers
   task automatic chk_out;
      logic [3:0]  er, et, ex, eq;
      logic        ei;
      logic [31:0] gv, cv, s;
      ei = 1'h0;
      s = m[14] & ~m[15];
      for (int i = 0; i < 4; i++) begin
         gv = m[i/2];
         cv = m[6+i];
         er[i] = gv[2] | cv[2];
         et[i] = gv[7] | cv[7];
         ex[i] = gv[3] | m[4+i/2][i%2];
         eq[i] = gv[4] | m[10+i][1];
         if (!(gv[1] | cv[1])) ei |= s[i] | s[i+4];
      end
      cmp(er, rst_o);
      cmp(et, test_o);
      cmp(ex, txpd_o);
      cmp(eq, rxpd_o);
      cmp({m[3][4:0], m[2][4:0]}, tsel_o);
      cmp(ei, irq_out);
   endtask : chk_out

   task automatic wr(input logic [17:0] x, input logic [7:0] d,
                     input logic [1:0] er);
      int n;
      int k;
      k = find(x);
      @(posedge clk_in);
      awaddr_in <= {x, 2'h0};
      wdata_in <= {24'($random(seed)), d};
      wstrb_in <= {3'($random(seed)), 1'h1};
      awvalid_in <= 1'h1;
      wvalid_in <= 1'h1;
      bready_in <= 1'h1;
      n = 0;
      do begin
         @(posedge clk_in);
         n++;
         if (awready_out === 1'h1) awvalid_in <= 1'h0;
         if (wready_out === 1'h1) wvalid_in <= 1'h0;
      end while (bvalid_out !== 1'h1 && n < 40);
      bready_in <= 1'h0;
      if (n >= 40) miscompares++;
      cmp(er, bresp_out);
      if (k == 14) m[14] &= ~d;
      else if (k >= 0) m[k] = (d & wm[k]) | on[k];
      repeat (2) @(posedge clk_in);
      chk_out;
   endtask : wr

   task automatic rd(input logic [17:0] x, input logic [1:0] er);
      int n;
      int k;
      k = find(x);
      @(posedge clk_in);
      araddr_in <= {x, 2'h0};
      arvalid_in <= 1'h1;
      rready_in <= 1'h1;
      n = 0;
      do begin
         @(posedge clk_in);
         n++;
         if (arready_out === 1'h1) arvalid_in <= 1'h0;
      end while (rvalid_out !== 1'h1 && n < 40);
      rready_in <= 1'h0;
      if (n >= 40) miscompares++;
      cmp((k < 0) ? 0 : m[k], rdata_out);
      cmp(er, rresp_out);
   endtask : rd

   task automatic pulse(input logic [7:0] a);
      @(posedge clk_in);
      alarm <= a;
      @(posedge clk_in);
      alarm <= 8'h00;
      m[14] |= a;
      repeat (2) @(posedge clk_in);
      chk_out;
   endtask : pulse

   // Hardware reset restores the model; second use checks mid-run reset
   task automatic do_reset;
      @(posedge clk_in);
      reset_in <= 1'h1;
      repeat (12) @(posedge clk_in);
      reset_in <= 1'h0;
      m = rv;
      for (int k = 0; k < 16; k++) rd(tbl[k], sctl_pkg::RESP_OKAY);
      chk_out;
   endtask : do_reset

   task automatic stop_test;
      $display("checks %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : stop_test

   ////////////////////////////////////////////////////////////////////////
   initial begin
      do_reset;
      rd(18'h30000, sctl_pkg::RESP_SLVERR);
      wr(18'h3FFFF, 8'hFF, sctl_pkg::RESP_SLVERR);
      wr(sctl_pkg::IDX_GCTL_A, 8'h00, sctl_pkg::RESP_OKAY);
      wr(sctl_pkg::IDX_CFG_AC, 8'h00, sctl_pkg::RESP_OKAY);
      pulse(8'h11);
      wr(sctl_pkg::IDX_CFG_AC, 8'h02, sctl_pkg::RESP_OKAY);
      wr(sctl_pkg::IDX_CFG_AC, 8'h00, sctl_pkg::RESP_OKAY);
      wr(sctl_pkg::IDX_GCTL_A, 8'h02, sctl_pkg::RESP_OKAY);
      wr(sctl_pkg::IDX_GCTL_A, 8'h00, sctl_pkg::RESP_OKAY);
      wr(sctl_pkg::IDX_ISTAT, 8'hFF, sctl_pkg::RESP_OKAY);
      wr(sctl_pkg::IDX_TSEL_B, 8'h15, sctl_pkg::RESP_OKAY);
      wr(sctl_pkg::IDX_CFG_BC, 8'h80, sctl_pkg::RESP_OKAY);
      // Random traffic covers the override and soft reset combinations
      for (int i = 0; i < 80; i++) begin
         wr(tbl[$random(seed) & 15], 8'($random(seed)) & 8'hFE,
            sctl_pkg::RESP_OKAY);
         pulse(8'($random(seed)));
         rd(tbl[$random(seed) & 15], sctl_pkg::RESP_OKAY);
      end
      do_reset;
      stop_test;
   end

   // Expected run is about 1230 cycles
   initial begin
      #2000000;
      miscompares++;
      stop_test;
   end
endmodule : serdes_channel_global_ctrl_test
